// ==== common/timer_pkg.sv ====
// Constants shared by the pulse and PWM timer core.
// Assumes a single CPU clock domain; all control bits arrive as plain ports.
package timer_pkg;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [15:0] CAP_ONE_PULSE = 16'hfffd;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;
  localparam int CH_ONE = 0;
  localparam int CH_TWO = 1;
  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'h0,
    MODE_ONE_PULSE = 2'h1,
    MODE_PWM = 2'h3
  } mode_t;
endpackage

// ==== core/timer_pulse_pwm.sv ====
// 16-bit timer core: compare, capture, forced compare, one pulse and PWM modes.
// Assumes the CPU drives the byte strobes and mode bits synchronously on I_CLK.
`timescale 1ns/1ns
module timer_pulse_pwm
(
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic i_capture_pin_one,
  input wire logic i_capture_pin_two,
  input wire logic i_ext_clock,
  input wire logic i_ext_edge_select,
  input wire logic [1:0] i_timer_clock_select,
  input wire logic i_one_pulse_select,
  input wire logic i_pwm_select,
  input wire logic i_pin_enable_one,
  input wire logic i_pin_enable_two,
  input wire logic i_level_after_match_one,
  input wire logic i_level_after_match_two,
  input wire logic i_force_level_bit_one,
  input wire logic i_force_level_bit_two,
  input wire logic i_trigger_edge_select,
  input wire logic i_capture_edge_two,
  input wire logic i_capture_irq_enable,
  input wire logic i_compare_irq_enable,
  input wire logic i_overflow_irq_enable,
  input wire logic i_cpu_irq_mask,
  input wire logic i_wait,
  input wire logic i_halt,
  input wire logic [7:0] i_wdata,
  input wire logic i_compare_high_byte_one_wr,
  input wire logic i_compare_low_byte_one_wr,
  input wire logic i_compare_high_byte_two_wr,
  input wire logic i_compare_low_byte_two_wr,
  input wire logic i_status_read,
  input wire logic i_capture_high_one_read,
  input wire logic i_capture_low_one_access,
  input wire logic i_capture_high_two_read,
  input wire logic i_capture_low_two_access,
  input wire logic i_compare_low_one_access,
  input wire logic i_compare_low_two_access,
  input wire logic i_counter_low_access,
  output logic o_compare_pin_one,
  output logic o_compare_pin_one_oe,
  output logic o_compare_pin_two,
  output logic o_compare_pin_two_oe,
  output logic [15:0] o_counter,
  output logic [15:0] o_capture_value_one,
  output logic [15:0] o_capture_value_two,
  output logic [15:0] o_compare_value_one,
  output logic [15:0] o_compare_value_two,
  output logic o_capture_flag_one,
  output logic o_capture_flag_two,
  output logic o_match_flag_one,
  output logic o_match_flag_two,
  output logic o_overflow_flag,
  output logic o_timer_irq,
  output logic o_wait_wake
);

  logic [2:0] cap1_sync_reg;
  logic [2:0] cap2_sync_reg;
  logic [2:0] ext_sync_reg;
  logic [2:0] pre_reg;
  logic halt_prev_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] cmp_reg [2];
  logic [15:0] cap_reg [2];
  logic [1:0] cmp_inhibit_reg;
  logic [1:0] cap_lock_reg;
  logic [1:0] cap_flag_reg;
  logic [1:0] cmp_flag_reg;
  logic tof_reg;
  logic [1:0] cap_arm_reg;
  logic [1:0] cmp_arm_reg;
  logic tof_arm_reg;
  logic [1:0] halt_arm_reg;
  logic [1:0] pin_reg;
  timer_pkg::mode_t mode;
  logic tick;
  logic ext_edge;
  logic [2:0] div_mask;
  logic edge_one;
  logic edge_two;
  logic halt_exit;
  logic [1:0] match;
  logic [1:0] cap_set;
  logic [1:0] cmp_set;
  logic [1:0] cap_clr;
  logic [1:0] cmp_clr;
  logic [1:0] cap_take;
  logic [15:0] cap_data [2];
  logic tof_set;
  logic trigger;
  logic irq;

  // Asynchronous pins: the first stage feeds only the second
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      cap1_sync_reg <= 3'h0;
      cap2_sync_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
    end
    else
    begin
      cap1_sync_reg <= {cap1_sync_reg[1:0], i_capture_pin_one};
      cap2_sync_reg <= {cap2_sync_reg[1:0], i_capture_pin_two};
      ext_sync_reg <= {ext_sync_reg[1:0], i_ext_clock};
    end
  end

  assign edge_one = i_trigger_edge_select ? (cap1_sync_reg[1] & ~cap1_sync_reg[2])
                                          : (~cap1_sync_reg[1] & cap1_sync_reg[2]);
  assign edge_two = i_capture_edge_two ? (cap2_sync_reg[1] & ~cap2_sync_reg[2])
                                       : (~cap2_sync_reg[1] & cap2_sync_reg[2]);
  assign ext_edge = i_ext_edge_select ? (ext_sync_reg[1] & ~ext_sync_reg[2])
                                      : (~ext_sync_reg[1] & ext_sync_reg[2]);

  always_comb
  begin
    if (i_pwm_select)
      mode = timer_pkg::MODE_PWM;
    else if (i_one_pulse_select)
      mode = timer_pkg::MODE_ONE_PULSE;
    else
      mode = timer_pkg::MODE_NORMAL;
  end

  always_comb
  begin
    unique case (i_timer_clock_select)
      timer_pkg::CLK_DIV4: div_mask = timer_pkg::MASK_DIV4;
      timer_pkg::CLK_DIV2: div_mask = timer_pkg::MASK_DIV2;
      timer_pkg::CLK_DIV8: div_mask = timer_pkg::MASK_DIV8;
      timer_pkg::CLK_EXT: div_mask = timer_pkg::MASK_DIV8;
    endcase
  end

  // Halt stops the prescaler too, so no tick leaks out while frozen
  assign tick = !i_halt && ((i_timer_clock_select == timer_pkg::CLK_EXT) ? ext_edge
                                                                         : ((pre_reg & div_mask) == div_mask));

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
      pre_reg <= 3'h0;
    else if (!i_halt)
      pre_reg <= pre_reg + 3'h1;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
      halt_prev_reg <= 1'b0;
    else
      halt_prev_reg <= i_halt;
  end
  assign halt_exit = halt_prev_reg && !i_halt;

  assign trigger = (mode == timer_pkg::MODE_ONE_PULSE) && edge_one && !i_halt;

  // Compare keeps matching whatever the pin enable says
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      match[i] = tick && !cmp_inhibit_reg[i] && (cnt_reg == cmp_reg[i]);
  end

  always_comb
  begin
    cnt_next = cnt_reg;
    if (i_halt)
      cnt_next = cnt_reg;
    else if (trigger)
      cnt_next = timer_pkg::CNT_RELOAD;
    else if ((mode == timer_pkg::MODE_PWM) && match[timer_pkg::CH_TWO])
      cnt_next = timer_pkg::CNT_RELOAD;
    else if (tick)
      cnt_next = cnt_reg + 16'h0001;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
      cnt_reg <= timer_pkg::CNT_RESET;
    else
      cnt_reg <= cnt_next;
  end

  assign tof_set = tick && (cnt_reg == timer_pkg::CNT_TOP) && (cnt_next != timer_pkg::CNT_RELOAD);

  // Compare values: high byte write suspends compare until low byte lands
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      cmp_reg[0] <= timer_pkg::CMP_RESET;
      cmp_reg[1] <= timer_pkg::CMP_RESET;
      cmp_inhibit_reg <= 2'h0;
    end
    else
    begin
      if (i_compare_high_byte_one_wr)
      begin
        cmp_reg[0][15:8] <= i_wdata;
        cmp_inhibit_reg[0] <= 1'b1;
      end
      if (i_compare_low_byte_one_wr)
      begin
        cmp_reg[0][7:0] <= i_wdata;
        cmp_inhibit_reg[0] <= 1'b0;
      end
      if (i_compare_high_byte_two_wr)
      begin
        cmp_reg[1][15:8] <= i_wdata;
        cmp_inhibit_reg[1] <= 1'b1;
      end
      if (i_compare_low_byte_two_wr)
      begin
        cmp_reg[1][7:0] <= i_wdata;
        cmp_inhibit_reg[1] <= 1'b0;
      end
    end
  end

  // Flag set causes per mode
  always_comb
  begin
    cap_set[0] = ((mode == timer_pkg::MODE_NORMAL) && edge_one && !i_halt) || trigger
                 || ((mode == timer_pkg::MODE_PWM) && match[timer_pkg::CH_TWO])
                 || (halt_exit && halt_arm_reg[0]);
    cap_set[1] = (edge_two && !i_halt) || (halt_exit && halt_arm_reg[1]);
    cmp_set[0] = (mode == timer_pkg::MODE_NORMAL) && match[timer_pkg::CH_ONE];
    cmp_set[1] = (mode != timer_pkg::MODE_PWM) && match[timer_pkg::CH_TWO];
    cap_take[0] = (mode == timer_pkg::MODE_NORMAL) && edge_one && !i_halt;
    cap_take[1] = edge_two && !i_halt;
    cap_data[0] = cnt_reg;
    cap_data[1] = cnt_reg;
    if (trigger)
    begin
      cap_take[0] = 1'b1;
      cap_data[0] = timer_pkg::CAP_ONE_PULSE;
    end
    for (int i = 0; i < 2; i++)
    begin
      if (halt_exit && halt_arm_reg[i])
        cap_take[i] = 1'b1;
    end
    cap_clr[0] = cap_arm_reg[0] && i_capture_low_one_access;
    cap_clr[1] = cap_arm_reg[1] && i_capture_low_two_access;
    cmp_clr[0] = cmp_arm_reg[0] && (i_compare_low_one_access || i_compare_low_byte_one_wr);
    cmp_clr[1] = cmp_arm_reg[1] && (i_compare_low_two_access || i_compare_low_byte_two_wr);
  end

  // Halt arms capture; pin one only arms in normal mode
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
      halt_arm_reg <= 2'h0;
    else if (!i_halt)
      halt_arm_reg <= 2'h0;
    else
    begin
      if (edge_one && (mode == timer_pkg::MODE_NORMAL))
        halt_arm_reg[0] <= 1'b1;
      if (edge_two)
        halt_arm_reg[1] <= 1'b1;
    end
  end

  // Capture registers; reading the high byte freezes transfer until low byte read
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      cap_reg[0] <= 16'h0000;
      cap_reg[1] <= 16'h0000;
      cap_lock_reg <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (cap_take[i] && !cap_lock_reg[i])
          cap_reg[i] <= cap_data[i];
      end
      if (i_capture_high_one_read)
        cap_lock_reg[0] <= 1'b1;
      else if (i_capture_low_one_access)
        cap_lock_reg[0] <= 1'b0;
      if (i_capture_high_two_read)
        cap_lock_reg[1] <= 1'b1;
      else if (i_capture_low_two_access)
        cap_lock_reg[1] <= 1'b0;
    end
  end

  // Two-step clear: status read arms, low byte access clears; a set always wins
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      cap_flag_reg <= 2'h0;
      cmp_flag_reg <= 2'h0;
      tof_reg <= 1'b0;
      cap_arm_reg <= 2'h0;
      cmp_arm_reg <= 2'h0;
      tof_arm_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        cap_flag_reg[i] <= cap_set[i] || (cap_flag_reg[i] && !cap_clr[i]);
        cmp_flag_reg[i] <= cmp_set[i] || (cmp_flag_reg[i] && !cmp_clr[i]);
        if (cap_clr[i] || !cap_flag_reg[i])
          cap_arm_reg[i] <= 1'b0;
        else if (i_status_read)
          cap_arm_reg[i] <= 1'b1;
        if (cmp_clr[i] || !cmp_flag_reg[i])
          cmp_arm_reg[i] <= 1'b0;
        else if (i_status_read)
          cmp_arm_reg[i] <= 1'b1;
      end
      tof_reg <= tof_set || (tof_reg && !(tof_arm_reg && i_counter_low_access));
      if ((tof_arm_reg && i_counter_low_access) || !tof_reg)
        tof_arm_reg <= 1'b0;
      else if (i_status_read)
        tof_arm_reg <= 1'b1;
    end
  end

  // Pin latches start low and move only on matches, triggers or forces
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
      pin_reg <= 2'h0;
    else
    begin
      unique case (mode)
        timer_pkg::MODE_NORMAL:
        begin
          if (match[timer_pkg::CH_ONE] || i_force_level_bit_one)
            pin_reg[0] <= i_level_after_match_one;
          if (match[timer_pkg::CH_TWO] || i_force_level_bit_two)
            pin_reg[1] <= i_level_after_match_two;
        end
        timer_pkg::MODE_ONE_PULSE:
        begin
          // Force bits are not looked at here, nor is pin two driven
          if (trigger)
            pin_reg[0] <= i_level_after_match_two;
          else if (match[timer_pkg::CH_ONE])
            pin_reg[0] <= i_level_after_match_one;
        end
        timer_pkg::MODE_PWM:
        begin
          if (match[timer_pkg::CH_TWO])
            pin_reg[0] <= i_level_after_match_two;
          else if (match[timer_pkg::CH_ONE])
            pin_reg[0] <= i_level_after_match_one;
        end
        default:
          pin_reg <= pin_reg;
      endcase
    end
  end

  // Shared vector; irq is independent of halt so it cannot wake it
  assign irq = !i_cpu_irq_mask && ((i_capture_irq_enable && |cap_flag_reg)
                                   || (i_compare_irq_enable && |cmp_flag_reg)
                                   || (i_overflow_irq_enable && tof_reg));
  assign o_timer_irq = irq;
  assign o_wait_wake = irq && i_wait;

  assign o_compare_pin_one = pin_reg[0];
  assign o_compare_pin_one_oe = i_pin_enable_one;
  assign o_compare_pin_two = pin_reg[1];
  assign o_compare_pin_two_oe = i_pin_enable_two;
  assign o_counter = cnt_reg;
  assign o_capture_value_one = cap_reg[0];
  assign o_capture_value_two = cap_reg[1];
  assign o_compare_value_one = cmp_reg[0];
  assign o_compare_value_two = cmp_reg[1];
  assign o_capture_flag_one = cap_flag_reg[0];
  assign o_capture_flag_two = cap_flag_reg[1];
  assign o_match_flag_one = cmp_flag_reg[0];
  assign o_match_flag_two = cmp_flag_reg[1];
  assign o_overflow_flag = tof_reg;

endmodule

// ==== tb/timer_pulse_pwm_checker.sv ====
// Concurrent checks on the pulse and PWM timer core ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module timer_pulse_pwm_checker
(
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic i_one_pulse_select,
  input wire logic i_pwm_select,
  input wire logic i_level_after_match_one,
  input wire logic i_force_level_bit_one,
  input wire logic i_capture_irq_enable,
  input wire logic i_compare_irq_enable,
  input wire logic i_overflow_irq_enable,
  input wire logic i_cpu_irq_mask,
  input wire logic i_wait,
  input wire logic i_halt,
  input wire logic o_compare_pin_one,
  input wire logic o_compare_pin_two,
  input wire logic [15:0] o_counter,
  input wire logic [15:0] o_capture_value_one,
  input wire logic [15:0] o_compare_value_one,
  input wire logic [15:0] o_compare_value_two,
  input wire logic o_capture_flag_one,
  input wire logic o_capture_flag_two,
  input wire logic o_match_flag_one,
  input wire logic o_match_flag_two,
  input wire logic o_overflow_flag,
  input wire logic o_timer_irq,
  input wire logic o_wait_wake
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  logic pulse_mode;
  logic pulse_like;
  logic any_irq;
  assign pulse_mode = i_one_pulse_select && !i_pwm_select;
  assign pulse_like = i_one_pulse_select || i_pwm_select;
  assign any_irq = i_capture_irq_enable && (o_capture_flag_one || o_capture_flag_two)
    || i_compare_irq_enable && (o_match_flag_one || o_match_flag_two) || i_overflow_irq_enable && o_overflow_flag;
  chk_force_copy: assert property (!pulse_like && i_force_level_bit_one |=>
    o_compare_pin_one == $past(i_level_after_match_one)) else $error("forced level not on pin one");
  chk_pulse_flag_one: assert property (pulse_mode |=> !$rose(o_match_flag_one))
    else $error("match flag one set in one pulse mode");
  chk_pwm_no_match: assert property (i_pwm_select |=> !$rose(o_match_flag_one) && !$rose(o_match_flag_two))
    else $error("match flag set in pwm mode");
  chk_trigger_load: assert property (pulse_mode && $past(pulse_mode) && $rose(o_capture_flag_one) |->
    o_counter == 16'hfffc && o_capture_value_one == 16'hfffd) else $error("trigger load values wrong");
  chk_pwm_reload: assert property ($past(i_pwm_select) && $past(o_counter) == $past(o_compare_value_two)
    && o_counter != $past(o_counter) |-> o_counter == 16'hfffc) else $error("pwm period reload wrong");
  chk_match_level: assert property ($past(pulse_like) && $past(o_counter) == $past(o_compare_value_one)
    && o_counter != $past(o_counter) |-> o_compare_pin_one == $past(i_level_after_match_one))
    else $error("pin one level after match one wrong");
  chk_pulse_pin_two: assert property (pulse_mode |=> $stable(o_compare_pin_two))
    else $error("pin two moved in one pulse mode");
  chk_irq_gate: assert property (o_timer_irq == (!i_cpu_irq_mask && any_irq))
    else $error("timer interrupt gating wrong");
  chk_wait_wake: assert property (o_wait_wake == (o_timer_irq && i_wait))
    else $error("wait wake-up wrong");
  chk_halt_freeze: assert property (i_halt |=> $stable(o_counter))
    else $error("counter moved in halt");
  cover property (pulse_mode && $rose(o_capture_flag_one));
  cover property (i_pwm_select && $fell(o_compare_pin_one));
  cover property ($fell(i_halt));
endmodule
bind timer_pulse_pwm timer_pulse_pwm_checker i_timer_pulse_pwm_checker (.*);

// ==== tb/timer_pins_model.sv ====
// Pin-side model: capture pin pulses and the external timer clock.
// Assumes fire requests are single-cycle pulses on the CPU clock.
`timescale 1ns/1ns
module timer_pins_model
(
  input wire logic i_clk,
  input wire logic i_fire_one,
  input wire logic i_fire_two,
  input wire logic i_ext_run,
  output logic o_cap_one,
  output logic o_cap_two,
  output logic o_ext_clk
);
  logic [3:0] one_reg = 4'h0;
  logic [3:0] two_reg = 4'h0;
  logic [1:0] phase_reg = 2'h0;
  logic ext_reg = 1'b0;
  // Four-cycle pulses give one rising and one falling edge past the synchroniser
  assign o_cap_one = |one_reg;
  assign o_cap_two = |two_reg;
  assign o_ext_clk = ext_reg;
  always @(posedge i_clk)
  begin
    one_reg <= {one_reg[2:0], i_fire_one};
    two_reg <= {two_reg[2:0], i_fire_two};
    phase_reg <= phase_reg + 2'h1;
    // Period of eight CPU cycles keeps the external rate under a quarter
    if (i_ext_run && phase_reg == 2'h3)
      ext_reg <= !ext_reg;
  end
endmodule

// ==== tb/timer_pulse_pwm_bench.sv ====
// Self-checking bench for the pulse and PWM timer core.
// Assumes the pin model drives the capture pins and external clock.
`timescale 1ns/1ns
module timer_pulse_pwm_bench;
  logic I_CLK = 1'b0, I_RESET_N = 1'b0, i_ext_edge_select = 1'b1, i_capture_edge_two = 1'b1;
  logic i_capture_pin_one, i_capture_pin_two, i_ext_clock, i_trigger_edge_select = 1'b1;
  logic [1:0] i_timer_clock_select = 2'h0;
  logic i_one_pulse_select = 1'b0, i_pwm_select = 1'b0, i_pin_enable_one = 1'b0, i_pin_enable_two = 1'b0;
  logic i_level_after_match_one = 1'b0, i_level_after_match_two = 1'b0, i_status_read = 1'b0;
  logic i_force_level_bit_one = 1'b0, i_force_level_bit_two = 1'b0, i_wait = 1'b0, i_halt = 1'b0;
  logic i_capture_irq_enable = 1'b0, i_compare_irq_enable = 1'b0, i_overflow_irq_enable = 1'b0, i_cpu_irq_mask = 1'b1;
  logic [7:0] i_wdata = 8'h00;
  logic i_compare_high_byte_one_wr = 1'b0, i_compare_low_byte_one_wr = 1'b0, i_capture_high_one_read = 1'b0;
  logic i_compare_high_byte_two_wr = 1'b0, i_compare_low_byte_two_wr = 1'b0, i_capture_high_two_read = 1'b0;
  logic i_capture_low_one_access, i_capture_low_two_access, i_compare_low_one_access;
  logic i_compare_low_two_access, i_counter_low_access, fire_one = 1'b0, fire_two = 1'b0, ext_run = 1'b0;
  logic [4:0] low_acc = 5'h00;
  logic o_compare_pin_one, o_compare_pin_one_oe, o_compare_pin_two, o_compare_pin_two_oe, o_wait_wake;
  logic [15:0] o_counter, o_capture_value_one, o_capture_value_two, o_compare_value_one, o_compare_value_two;
  logic o_capture_flag_one, o_capture_flag_two, o_match_flag_one, o_match_flag_two, o_overflow_flag, o_timer_irq;
  logic [15:0] rate [4] = '{16'h000a, 16'h0014, 16'h0005, 16'h0005};
  int errors = 0, total_checks = 0;
  assign {i_capture_low_one_access, i_capture_low_two_access, i_compare_low_one_access} = low_acc[4:2];
  assign {i_compare_low_two_access, i_counter_low_access} = low_acc[1:0];
  timer_pulse_pwm i_timer_pulse_pwm (.*);
  timer_pins_model i_timer_pins_model (.i_clk(I_CLK), .i_fire_one(fire_one), .i_fire_two(fire_two),
    .i_ext_run(ext_run), .o_cap_one(i_capture_pin_one), .o_cap_two(i_capture_pin_two), .o_ext_clk(i_ext_clock));
  initial
    forever #5 I_CLK = ~I_CLK;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One strobe cycle per byte; the high byte leaves that compare suspended
  task automatic write_half(input logic one, input logic hi, input logic [7:0] b);
    @(posedge I_CLK);
    i_wdata <= b;
    {i_compare_high_byte_one_wr, i_compare_low_byte_one_wr} <= {one && hi, one && !hi};
    {i_compare_high_byte_two_wr, i_compare_low_byte_two_wr} <= {!one && hi, !one && !hi};
    @(posedge I_CLK);
    {i_compare_high_byte_one_wr, i_compare_low_byte_one_wr, i_compare_high_byte_two_wr, i_compare_low_byte_two_wr} <= 4'h0;
  endtask
  task automatic write_cmp(input logic one, input logic [15:0] v);
    write_half(one, 1'b1, v[15:8]);
    write_half(one, 1'b0, v[7:0]);
  endtask
  task automatic clear_flags();
    @(posedge I_CLK);
    i_status_read <= 1'b1;
    @(posedge I_CLK);
    i_status_read <= 1'b0;
    low_acc <= 5'h1f;
    @(posedge I_CLK);
    low_acc <= 5'h00;
    @(posedge I_CLK);
  endtask
  task automatic await(ref logic sig, input logic v);
    for (int k = 0; k < 300 && sig !== v; k++)
      @(posedge I_CLK);
    // A wait that runs out is a failure in itself
    if (sig !== v)
      errors++;
  endtask
  task automatic reach(input logic [15:0] v);
    for (int k = 0; k < 3000 && o_counter !== v; k++)
      @(posedge I_CLK);
    if (o_counter !== v)
      errors++;
  endtask
  task automatic hold_time(input logic v, output int n);
    n = 0;
    while (o_compare_pin_one === v && n < 100)
    begin
      @(posedge I_CLK);
      n++;
    end
  endtask
  initial
  begin
    logic [15:0] mark;
    int len;
    repeat (12) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    {i_pin_enable_one, i_pin_enable_two} <= 2'h3;
    @(posedge I_CLK);
    check("reset counter", o_counter, 16'hfffc);
    check("reset compare", o_compare_value_one, 16'h8000);
    for (int c = 0; c < 4; c++)
    begin
      i_timer_clock_select <= c[1:0];
      ext_run <= (c == 3);
      repeat (8) @(posedge I_CLK);
      mark = o_counter;
      repeat (40) @(posedge I_CLK);
      check("count rate", o_counter - mark, rate[c]);
    end
    i_timer_clock_select <= 2'h1;
    ext_run <= 1'b0;
    {i_level_after_match_one, i_force_level_bit_one} <= 2'h3;
    repeat (3) @(posedge I_CLK);
    {i_level_after_match_one, i_force_level_bit_one} <= 2'h0;
    check("forced pin", o_compare_pin_one, 1'b1);
    check("forced flag", o_match_flag_one, 1'b0);
    // Pins released: the compare must still match and move the latch
    {i_pin_enable_one, i_pin_enable_two} <= 2'h0;
    write_half(1'b1, 1'b1, 8'h01);
    reach(16'h0104);
    check("suspended match", o_match_flag_one, 1'b0);
    write_half(1'b1, 1'b0, 8'h20);
    reach(16'h0124);
    check("resumed match", o_match_flag_one, 1'b1);
    check("disabled pin", {o_compare_pin_one_oe, o_compare_pin_one}, 2'h0);
    clear_flags();
    {i_pin_enable_one, i_pin_enable_two} <= 2'h3;
    write_cmp(1'b1, 16'h0008);
    {i_level_after_match_two, i_force_level_bit_two, i_one_pulse_select} <= 3'h7;
    {i_level_after_match_one, i_force_level_bit_one} <= 2'h3;
    repeat (3) @(posedge I_CLK);
    check("ignored force", o_compare_pin_one, 1'b0);
    check("pin two idle", {o_compare_pin_one_oe, o_compare_pin_two}, 2'h2);
    i_level_after_match_one <= 1'b0;
    {fire_one, fire_two} <= 2'h3;
    @(posedge I_CLK);
    {fire_one, fire_two} <= 2'h0;
    await(o_capture_flag_one, 1'b1);
    check("pulse start count", o_counter, 16'hfffc);
    check("pulse capture", o_capture_value_one, 16'hfffd);
    check("pulse level", o_compare_pin_one, 1'b1);
    await(o_compare_pin_one, 1'b0);
    check("pulse end count", o_counter, 16'h0009);
    check("pulse match flag", o_match_flag_one, 1'b0);
    check("second capture", o_capture_flag_two, 1'b1);
    check("overflow", o_overflow_flag, 1'b1);
    repeat (40) @(posedge I_CLK);
    check("after pulse", o_compare_pin_one, 1'b0);
    clear_flags();
    write_cmp(1'b1, 16'h0004);
    write_cmp(1'b0, 16'h0010);
    // Falling-edge trigger: the leading rising edge of the pulse must not fire
    i_trigger_edge_select <= 1'b0;
    {i_level_after_match_one, i_level_after_match_two, fire_one} <= 3'h5;
    @(posedge I_CLK);
    fire_one <= 1'b0;
    check("period value", o_compare_value_two, 16'h0010);
    repeat (4) @(posedge I_CLK);
    check("rising ignored", o_capture_flag_one, 1'b0);
    await(o_capture_flag_one, 1'b1);
    i_pwm_select <= 1'b1;
    clear_flags();
    await(o_compare_pin_one, 1'b0);
    await(o_compare_pin_one, 1'b1);
    hold_time(1'b1, len);
    check("high time", len[15:0], 16'h0018);
    hold_time(1'b0, len);
    check("low time", len[15:0], 16'h0012);
    check("pwm match flags", {o_match_flag_one, o_match_flag_two}, 2'h0);
    check("period flag", o_capture_flag_one, 1'b1);
    {i_capture_irq_enable, i_compare_irq_enable, i_overflow_irq_enable, i_cpu_irq_mask, i_wait} <= 5'h1d;
    repeat (2) @(posedge I_CLK);
    check("irq", o_timer_irq, 1'b1);
    check("wait wake", o_wait_wake, 1'b1);
    i_cpu_irq_mask <= 1'b1;
    @(posedge I_CLK);
    check("masked irq", o_timer_irq, 1'b0);
    // Equal levels: after one full period the pin must sit still
    {i_level_after_match_one, i_level_after_match_two} <= 2'h0;
    repeat (50) @(posedge I_CLK);
    hold_time(1'b0, len);
    check("equal levels", len[15:0], 16'h0064);
    {i_pwm_select, i_one_pulse_select, i_wait} <= 3'h0;
    clear_flags();
    i_halt <= 1'b1;
    repeat (2) @(posedge I_CLK);
    mark = o_counter;
    fire_two <= 1'b1;
    @(posedge I_CLK);
    fire_two <= 1'b0;
    repeat (20) @(posedge I_CLK);
    check("halt counter", o_counter, mark);
    check("halt flag", o_capture_flag_two, 1'b0);
    i_halt <= 1'b0;
    repeat (3) @(posedge I_CLK);
    check("exit flag", o_capture_flag_two, 1'b1);
    check("exit capture", o_capture_value_two, mark);
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge I_CLK);
    errors++;
    give_verdict();
  end
endmodule
